// ===== logic/flag_defines.svh
`ifndef FLAG_DEFINES_SVH
`define FLAG_DEFINES_SVH

// register byte offsets
`define OFS_STATUS 12'h000
`define OFS_MASK 12'h004
`define OFS_CONTROL 12'h008
`define OFS_SOURCE 12'h00C
`define OFS_PRESCALE 12'h010

// status bit positions
`define BIT_NO_ACK_FLAG 1
`define BIT_ACCESS_READY_FLAG 2

// control bit positions
`define BIT_RUN 0
`define BIT_REPEAT 1
`define BIT_STOP 2
`define BIT_START 3
`define BIT_FREE 4
`define BIT_MASTER 5

// interrupt source codes
`define SRC_NONE 3'h0
`define SRC_NO_ACK_FLAG 3'h2
`define SRC_ACCESS_READY_FLAG 3'h3

// reset values
`define RST_PRESCALE 8'h00

`endif

// ===== logic/flag_pkg.sv
package flag_pkg;
  typedef enum logic [1:0] {
    PULSE_IDLE = 2'b00,
    PULSE_HIGH = 2'b01
  } pulse_e;
endpackage : flag_pkg

// ===== logic/ready_ack_flags.sv
// Contract
// - access-ready flag at status bit two
// - clear ready when current registers used
// - write one clears ready, zero keeps
// - non-repeat, no stop: set at count zero
// - non-repeat with stop: stop, no set
// - repeat mode: set per transmitted word
// - start, stop, data write clear ready
// - early data write: set then clear
// - set after address ack or start
// - no-ack flag at status bit one
// - ack from receiver clears no-ack
// - write one clears no-ack flag
// - source read with no-ack code clears
// - module or device reset clears both
// - ready flag polled and interrupts
// - no-ack received sets no-ack flag
// - general call reports no-ack anyway
`timescale 1ns/1ps
`include "flag_defines.svh"

module ready_ack_flags
  import flag_pkg::*;
#(
  parameter int PRESCALE_W = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // bus-side events from the shift engine, pclk domain
  input wire logic count_zero,
  input wire logic word_done,
  input wire logic addr_ack_done,
  input wire logic start_done,
  input wire logic ack_seen,
  input wire logic no_ack_flag_seen,
  input wire logic general_call,
  input wire logic data_loaded,
  // controls to the shift engine
  output logic stop_gen,
  output logic data_write,
  output logic module_run,
  output logic repeat_mode,
  output logic free_format,
  output logic master_mode,
  // interrupt
  output logic irq
);

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic access;
  logic wr;
  logic rd;
  logic [31:0] wdat;
  logic [31:0] status_q;
  logic [31:0] mask_q;
  logic [5:0] control_q;
  logic [PRESCALE_W-1:0] prescale_q;
  logic [PRESCALE_W-1:0] pre_cnt_q;
  logic tick;
  logic [2:0] source;
  logic access_ready_flag_q;
  logic no_ack_flag_q;
  logic pend_q;
  pulse_e pulse_q;

  // per-register strobes, decoded once and shared below
  logic wr_status;
  logic wr_mask;
  logic wr_control;
  logic wr_prescale;
  logic rd_source;
  logic read_setup;

  assign access = psel & penable;
  assign wr = access & pwrite;
  assign rd = access & ~pwrite;
  assign wdat = pwdata;
  // zero wait states: every register answers at once
  assign pready = 1'b1;
  // read data fetched in setup so it stands through access
  assign read_setup = psel & ~penable & ~pwrite;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // true for the five implemented word addresses
  function automatic logic mapped(input logic [11:0] a);
    mapped = hit(a, `OFS_STATUS) | hit(a, `OFS_MASK) | hit(a, `OFS_CONTROL) |
      hit(a, `OFS_SOURCE) | hit(a, `OFS_PRESCALE);
  endfunction : mapped

  // status and mask share one layout
  function automatic logic [31:0] pack_flags(input logic ready, input logic no_ack_flag);
    pack_flags = 32'h0000_0000;
    pack_flags[`BIT_ACCESS_READY_FLAG] = ready;
    pack_flags[`BIT_NO_ACK_FLAG] = no_ack_flag;
  endfunction : pack_flags

  // unmapped accesses are refused and change nothing
  assign pslverr = access & ~mapped(paddr);
  assign wr_status = wr & hit(paddr, `OFS_STATUS);
  assign wr_mask = wr & hit(paddr, `OFS_MASK);
  assign wr_control = wr & hit(paddr, `OFS_CONTROL);
  assign wr_prescale = wr & hit(paddr, `OFS_PRESCALE);
  assign rd_source = rd & hit(paddr, `OFS_SOURCE);

  // ---------------------------------------------------------------
  // control and configuration
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_q <= 6'h00;
    end else if (wr_control) begin
      control_q <= wdat[5:0];
    end else if (tick && control_q[`BIT_START]) begin
      // start request self-clears once taken
      control_q[`BIT_START] <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= 32'h0000_0000;
    end else if (wr_mask) begin
      mask_q <= pack_flags(wdat[`BIT_ACCESS_READY_FLAG], wdat[`BIT_NO_ACK_FLAG]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale_q <= PRESCALE_W'(`RST_PRESCALE);
    end else if (wr_prescale) begin
      prescale_q <= wdat[PRESCALE_W-1:0];
    end
  end

  assign module_run = control_q[`BIT_RUN];
  assign repeat_mode = control_q[`BIT_REPEAT];
  assign free_format = control_q[`BIT_FREE];
  assign master_mode = control_q[`BIT_MASTER];

  // ---------------------------------------------------------------
  // prescaled module clock enable
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt_q <= '0;
    end else if (!module_run || pre_cnt_q == prescale_q) begin
      pre_cnt_q <= '0;
    end else begin
      pre_cnt_q <= pre_cnt_q + 1'b1;
    end
  end
  assign tick = module_run & (pre_cnt_q == prescale_q);

  // ---------------------------------------------------------------
  // transmit data write strobe and stop generation
  // ---------------------------------------------------------------
  logic start_wr;
  logic stop_wr;
  assign data_write = data_loaded;
  assign start_wr = wr_control & wdat[`BIT_START];
  assign stop_wr = wr_control & wdat[`BIT_STOP];

  assign stop_gen = tick & master_mode & ~repeat_mode & control_q[`BIT_STOP] & count_zero;

  // ---------------------------------------------------------------
  // access-ready flag
  // ---------------------------------------------------------------
  logic access_ready_flag_set;
  logic access_ready_flag_clr;
  logic early_write;
  logic set_count;
  logic set_word;
  logic set_addr;
  logic set_start;
  logic clr_sw;
  logic clr_engine;
  logic early_take;
  logic early_drop;

  // count reaches zero
  // a pending stop request suppresses the flag, see stop_gen
  assign set_count = ~repeat_mode & ~control_q[`BIT_STOP] & count_zero;
  assign set_word = repeat_mode & word_done;
  // address ack or start
  // free format has no address phase, so start is the marker
  assign set_addr = ~free_format & addr_ack_done;
  assign set_start = free_format & start_done;
  // bus events only count on the prescaled clock, as master
  assign access_ready_flag_set = tick & master_mode & (set_count | set_word | set_addr | set_start);

  assign early_write = master_mode & data_loaded & ~access_ready_flag_q & ~access_ready_flag_set;
  // pending write becomes a flag lasting one tick period
  assign early_take = (pulse_q == PULSE_IDLE) & pend_q & tick;
  assign early_drop = (pulse_q == PULSE_HIGH) & tick;

  assign clr_sw = wr_status & wdat[`BIT_ACCESS_READY_FLAG];
  assign clr_engine = master_mode & (start_wr | stop_wr | data_loaded);
  assign access_ready_flag_clr = clr_sw | clr_engine;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_q <= PULSE_IDLE;
      pend_q <= 1'b0;
    end else if (!module_run) begin
      pulse_q <= PULSE_IDLE;
      pend_q <= 1'b0;
    end else begin
      if (early_write) begin
        pend_q <= 1'b1;
      end else if (tick) begin
        pend_q <= 1'b0;
      end
      case (pulse_q)
        PULSE_IDLE: begin
          if (pend_q && tick) begin
            pulse_q <= PULSE_HIGH;
          end
        end
        PULSE_HIGH: begin
          if (tick) begin
            pulse_q <= PULSE_IDLE;
          end
        end
        default: pulse_q <= PULSE_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      access_ready_flag_q <= 1'b0;
    end else if (!module_run) begin
      access_ready_flag_q <= 1'b0;
    end else if (access_ready_flag_set || early_take) begin
      // set wins over a clear in the same cycle
      access_ready_flag_q <= 1'b1;
    end else if (access_ready_flag_clr || early_drop) begin
      access_ready_flag_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // no-acknowledge flag
  // ---------------------------------------------------------------
  logic no_ack_flag_set;
  logic no_ack_flag_clr;
  logic no_ack_flag_wr_clr;
  logic no_ack_flag_src_clr;
  logic ack_clr;
  assign no_ack_flag_set = no_ack_flag_seen | (general_call & ack_seen);
  assign no_ack_flag_wr_clr = wr_status & wdat[`BIT_NO_ACK_FLAG];
  // source read clears
  // a masked flag never shows its code, so its read leaves it set
  assign no_ack_flag_src_clr = rd_source & (source == `SRC_NO_ACK_FLAG);
  assign no_ack_flag_clr = no_ack_flag_wr_clr | no_ack_flag_src_clr;
  // a general call ack must not undo the forced no-ack
  assign ack_clr = ack_seen & ~general_call;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      no_ack_flag_q <= 1'b0;
    end else if (!module_run) begin
      no_ack_flag_q <= 1'b0;
    end else if (no_ack_flag_set) begin
      no_ack_flag_q <= 1'b1;
    end else if (no_ack_flag_clr || ack_clr) begin
      no_ack_flag_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // status, source, interrupt, read data
  // ---------------------------------------------------------------
  logic irq_ready;
  logic irq_no_ack_flag;
  logic [31:0] rd_mux;

  assign status_q = pack_flags(access_ready_flag_q, no_ack_flag_q);

  assign irq_ready = access_ready_flag_q & mask_q[`BIT_ACCESS_READY_FLAG];
  assign irq_no_ack_flag = no_ack_flag_q & mask_q[`BIT_NO_ACK_FLAG];
  assign irq = irq_ready | irq_no_ack_flag;

  // no-ack has priority so a source read clears it first
  always_comb begin
    if (irq_no_ack_flag) begin
      source = `SRC_NO_ACK_FLAG;
    end else if (irq_ready) begin
      source = `SRC_ACCESS_READY_FLAG;
    end else begin
      source = `SRC_NONE;
    end
  end

  always_comb begin
    case (paddr)
      `OFS_STATUS: rd_mux = status_q;
      `OFS_MASK: rd_mux = mask_q;
      `OFS_CONTROL: rd_mux = {26'h0, control_q};
      `OFS_SOURCE: rd_mux = {29'h0, source};
      `OFS_PRESCALE: rd_mux = {{(32-PRESCALE_W){1'b0}}, prescale_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // status, mask, control and prescale reads are side-effect free
  // only the access-phase source read has a side effect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (read_setup) begin
      prdata <= rd_mux;
    end
  end

endmodule : ready_ack_flags

// ===== dv/flag_properties.sv
`timescale 1ns/1ps
module flag_checker (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // engine side
  input wire logic count_zero,
  input wire logic data_loaded,
  input wire logic data_write,
  input wire logic stop_gen,
  input wire logic module_run,
  input wire logic repeat_mode,
  input wire logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----
  // checks
  // ----
  AST_ZERO_WAIT: assert property (psel && penable |-> pready) else $error("pready low");
  AST_UNMAPPED: assert property (psel && penable && paddr > 12'h010 |-> pslverr) else $error("no error");
  AST_MAPPED: assert property (psel && penable && paddr <= 12'h010 && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("bad error");
  AST_DATA_PASS: assert property (data_loaded |-> ##[0:1] data_write) else $error("no data write");
  AST_STOP_ZERO: assert property (stop_gen |-> count_zero && !repeat_mode) else $error("stray stop");
  // run bit moves on writes only
  AST_RUN_WRITE: assert property ($changed(module_run) |-> $past(psel && penable && pwrite))
    else $error("run moved");
  AST_REPEAT_WRITE: assert property ($changed(repeat_mode) |-> $past(psel && penable && pwrite))
    else $error("repeat moved");
  // flags held clear in module reset
  AST_IRQ_HELD: assert property (!module_run [*2] |-> !irq) else $error("irq in reset");
endmodule : flag_checker
bind ready_ack_flags flag_checker i_chk (.*);

// ===== dv/engine_model.sv
`timescale 1ns/1ps
module engine_model (
  // clock
  input wire logic pclk,
  // request from bench
  input wire logic [5:0] kick,
  // event pulses: zero, word, addr ack, start, ack, no-ack
  output logic [5:0] ev
);
  logic [5:0] d_q = 6'h00;
  logic [5:0] ev_q = 6'h00;
  // one-cycle pulse, two cycles late like a real bit engine
  always_ff @(posedge pclk) begin
    d_q <= kick;
    ev_q <= d_q;
  end
  assign ev = ev_q;
endmodule : engine_model

// ===== dv/tb.sv
`timescale 1ns/1ps
`include "flag_defines.svh"
module tb;
  typedef struct {logic [31:0] ctl; logic [5:0] k; logic [31:0] st;} row_s;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic general_call = 1'b0;
  logic data_loaded = 1'b0;
  logic [5:0] kick = 6'h00;
  logic [5:0] ev;
  logic [31:0] prdata, rd;
  logic pready, pslverr, irq, err, stop_gen, data_write, module_run, repeat_mode, free_format, master_mode;
  int fail_count = 0;
  int n_tests = 0;
  int irq_hi = 0;
  int base;
  row_s rows[6] = '{'{32'h21, 6'h01, 32'h4}, '{32'h25, 6'h01, 32'h0}, '{32'h23, 6'h02, 32'h4},
    '{32'h21, 6'h04, 32'h4}, '{32'h31, 6'h08, 32'h4}, '{32'h21, 6'h20, 32'h2}};

  always #2.5 pclk = ~pclk;
  always @(posedge pclk) if (irq === 1'b1) irq_hi <= irq_hi + 1;

  ready_ack_flags i_dut (.*, .count_zero(ev[0]), .word_done(ev[1]), .addr_ack_done(ev[2]),
    .start_done(ev[3]), .ack_seen(ev[4]), .no_ack_flag_seen(ev[5]));
  engine_model i_eng (.pclk(pclk), .kick(kick), .ev(ev));

  task automatic end_sim;
    $display("compares %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      $display("[FAIL] pready expected 1 seen 0");
      fail_count++;
      end_sim();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic st(logic [31:0] e);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk("status", e, rd);
  endtask : st

  // engine events, optionally with a data load
  task automatic pulse(logic [5:0] k, logic dl);
    @(posedge pclk);
    kick <= k;
    data_loaded <= dl;
    @(posedge pclk);
    kick <= 6'h00;
    data_loaded <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask : pulse

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    st(32'h0);
    foreach (rows[j]) begin
      apb(1'b1, `OFS_CONTROL, 32'h0);
      apb(1'b1, `OFS_CONTROL, rows[j].ctl);
      pulse(rows[j].k, 1'b0);
      st(rows[j].st);
    end
    $display("table done");
    apb(1'b1, `OFS_MASK, 32'h6);
    @(posedge pclk);
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'b0, `OFS_SOURCE, 32'h0);
    chk("source", {29'h0, `SRC_NO_ACK_FLAG}, rd);
    st(32'h0);
    pulse(6'h20, 1'b0);
    pulse(6'h10, 1'b0);
    st(32'h0);
    pulse(6'h01, 1'b0);
    apb(1'b1, `OFS_STATUS, 32'h0);
    st(32'h4);
    apb(1'b1, `OFS_STATUS, 32'h4);
    st(32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    pulse(6'h20, 1'b0);
    apb(1'b1, `OFS_STATUS, 32'h2);
    st(32'h0);
    $display("clear test done");
    pulse(6'h01, 1'b0);
    pulse(6'h00, 1'b1);
    st(32'h0);
    base = irq_hi;
    pulse(6'h00, 1'b1);
    chk("early ready pulse", 32'h1, irq_hi - base);
    general_call <= 1'b1;
    pulse(6'h10, 1'b0);
    st(32'h2);
    general_call <= 1'b0;
    pulse(6'h01, 1'b0);
    apb(1'b1, `OFS_CONTROL, 32'h0);
    st(32'h0);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    $display("hand tests done");
    end_sim();
  end
endmodule : tb
